// ===== hdl/lin_channel.sv
// One LIN transceiver channel: mode field, enable gate, driver, receiver, wake, time-out
module lin_channel
    import lin_mode_pkg::*;
#(
    parameter int TXTO_LIMIT = TXTO_CYCLES
) (
    input  wire logic  mclk,
    input  wire logic  reset,
    lin_cfg_if.chan    cfg,
    input  wire logic  linTransmitInput,
    input  wire logic  busIn,
    output logic       busDriveEn,
    output logic       linReceiveOutput,
    output lin_mode_t  modeField,
    output logic       failFlag,
    input  wire logic  failClear,
    output logic       wakeEvent
);

    // ==========================================================
    // Mode field
    wire chipNormal   = (cfg.chipMode == CHIP_NORMAL);
    wire chipStopOrNm = chipNormal || (cfg.chipMode == CHIP_STOP);
    wire reqNormal    = cfg.cfgMode == LIN_NORMAL;
    wire reqRxOnly    = cfg.cfgMode == LIN_RXONLY;
    // Normal entered only from chip normal; rx-only from normal or stop
    wire reqOk        = reqNormal ? chipNormal :
                        reqRxOnly ? chipStopOrNm : 1'b1;
    wire acceptWr     = cfg.cfgWrite && reqOk;
    // Leaving normal/rx-only when chip no longer allows it: fall back to off
    wire dropActive   = ((modeField == LIN_NORMAL) || (modeField == LIN_RXONLY))
                        && !chipStopOrNm;
    lin_mode_t next_modeField;
    assign next_modeField = acceptWr ? cfg.cfgMode :
                            dropActive ? LIN_OFF : modeField;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            modeField <= MODE_RESET;
        end else begin
            modeField <= next_modeField;
        end
    end

    // ==========================================================
    // Enabling delay and pending-dominant gate
    logic [CNT_W-1:0] enCount;
    logic             armed;
    wire isNormal   = modeField == LIN_NORMAL;
    wire enDone     = isNormal && (enCount == CNT_W'(EN_CYCLES));
    logic waitHigh;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            enCount  <= '0;
            armed    <= 1'b0;
            waitHigh <= 1'b1;
        end else if (!isNormal || (acceptWr && cfg.cfgMode == LIN_NORMAL && !isNormal)) begin
            enCount  <= '0;
            armed    <= 1'b0;
            waitHigh <= 1'b1;
        end else if (!armed) begin
            enCount <= enCount + CNT_W'(1);
            if (enDone) begin
                armed    <= 1'b1;
                // Input already high as the delay ends: its next low is a new bit
                waitHigh <= !linTransmitInput;
            end
        end else if (linTransmitInput) begin
            waitHigh <= 1'b0;
        end
    end

    // ==========================================================
    // Transmit time-out
    logic [CNT_W-1:0] domCount;
    wire txDom      = armed && !waitHigh && !linTransmitInput;
    wire timedOut   = domCount >= CNT_W'(TXTO_LIMIT);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            domCount <= '0;
        end else if (!txDom) begin
            domCount <= '0;
        end else if (!timedOut) begin
            domCount <= domCount + CNT_W'(1);
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            failFlag <= 1'b0;
        end else if (txDom && timedOut) begin
            failFlag <= 1'b1;
        end else if (failClear) begin
            failFlag <= 1'b0;
        end
    end

    // Driver follows transmit input, off in rx-only and during time-out
    assign busDriveEn = isNormal && txDom && !timedOut;

    // ==========================================================
    // Wake detection
    logic [CNT_W-1:0] wkCount;
    logic             woken;
    logic             busPrev;
    wire isWake     = modeField == LIN_WAKECAP;
    wire wkLong     = wkCount >= CNT_W'(WAKE_CYCLES);
    wire wkHit      = isWake && !woken && busIn && !busPrev && wkLong;
    // Rearm only by leaving wake mode; no automatic rearm on chip mode change
    wire rearm      = !isWake;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wkCount <= '0;
            busPrev <= 1'b1;
            woken   <= 1'b0;
        end else begin
            busPrev <= busIn;
            wkCount <= (isWake && !busIn) ? (wkLong ? wkCount : wkCount + CNT_W'(1)) : '0;
            if (rearm) begin
                woken <= 1'b0;
            end else if (wkHit) begin
                woken <= 1'b1;
            end
        end
    end
    assign wakeEvent = wkHit;

    // ==========================================================
    // Receive output
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            linReceiveOutput <= 1'b1;
        end else if (isWake) begin
            linReceiveOutput <= !woken && !wkHit;
        end else if (isNormal || modeField == LIN_RXONLY) begin
            linReceiveOutput <= busIn;
        end else begin
            linReceiveOutput <= 1'b1;
        end
    end

    // ==========================================================
    // Checks
    property p_off_no_drive;
        @(posedge mclk) disable iff (reset) !isNormal |-> !busDriveEn;
    endproperty
    a_off_no_drive: assert property (p_off_no_drive) else $error("driver on outside normal");

    property p_off_no_wake;
        @(posedge mclk) disable iff (reset) (modeField == LIN_OFF) |-> !wakeEvent;
    endproperty
    a_off_no_wake: assert property (p_off_no_wake) else $error("wake in off mode");

    property p_wake_holds;
        @(posedge mclk) disable iff (reset)
            wakeEvent ##1 (isWake && !cfg.cfgWrite)
            |-> ##1 (!linReceiveOutput && modeField == LIN_WAKECAP);
    endproperty
    a_wake_holds: assert property (p_wake_holds) else $error("rx not held low after wake");

    property p_normal_gate;
        @(posedge mclk) disable iff (reset)
            (cfg.cfgWrite && reqNormal && !chipNormal && modeField != LIN_NORMAL)
            |=> modeField != LIN_NORMAL;
    endproperty
    a_normal_gate: assert property (p_normal_gate) else $error("normal entered outside chip normal");

    property p_no_early_drive;
        @(posedge mclk) disable iff (reset) $rose(isNormal) |-> !busDriveEn [*8];
    endproperty
    a_no_early_drive: assert property (p_no_early_drive) else $error("drive during enabling");

    property p_pending_low;
        @(posedge mclk) disable iff (reset)
            $rose(armed) && !$past(linTransmitInput) |-> !busDriveEn;
    endproperty
    a_pending_low: assert property (p_pending_low) else $error("pending low forwarded");

    property p_follow;
        @(posedge mclk) disable iff (reset)
            (isNormal && armed && !waitHigh && !timedOut) |-> busDriveEn == !linTransmitInput;
    endproperty
    a_follow: assert property (p_follow) else $error("driver not following input");

    property p_rx_follow;
        @(posedge mclk) disable iff (reset)
            (modeField == LIN_RXONLY) ##1 (modeField == LIN_RXONLY) |-> linReceiveOutput == $past(busIn);
    endproperty
    a_rx_follow: assert property (p_rx_follow) else $error("receive output wrong");

    property p_timeout;
        @(posedge mclk) disable iff (reset) (txDom && timedOut) |-> !busDriveEn ##1 failFlag;
    endproperty
    a_timeout: assert property (p_timeout) else $error("time-out not handled");

    c_enable: cover property (@(posedge mclk) disable iff (reset) $rose(armed));
    c_wake:   cover property (@(posedge mclk) disable iff (reset) wakeEvent);
    c_drive:  cover property (@(posedge mclk) disable iff (reset) busDriveEn);

endmodule

// ===== include/lin_mode_pkg.sv
// Package: constants and types for the dual LIN transceiver mode control
package lin_mode_pkg;

    // Transceiver mode codes, off is the reset value
    typedef enum logic [1:0] {
        LIN_OFF      = 2'h0,
        LIN_WAKECAP  = 2'h1,
        LIN_RXONLY   = 2'h2,
        LIN_NORMAL   = 2'h3
    } lin_mode_t;

    // Chip operating modes seen by this block
    typedef enum logic [2:0] {
        CHIP_NORMAL   = 3'h0,
        CHIP_STOP     = 3'h1,
        CHIP_SLEEP    = 3'h2,
        CHIP_RESTART  = 3'h3,
        CHIP_FAILSAFE = 3'h4,
        CHIP_INIT     = 3'h5
    } chip_mode_t;

    localparam lin_mode_t MODE_RESET = LIN_OFF;

    localparam int CLK_PERIOD_NS = 100;

    // Enabling time, longest figure
    localparam int EN_TIME_NS   = 10000;
    localparam int EN_CYCLES    = EN_TIME_NS / CLK_PERIOD_NS;

    // Transmit dominant time-out, least figure
    localparam int TXTO_TIME_US = 20000;
    localparam int TXTO_CYCLES  = (TXTO_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Wake filter: least dominant time on the bus
    localparam int WAKE_TIME_NS = 30000;
    localparam int WAKE_CYCLES  = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int CNT_W = 18;

endpackage

// ===== include/lin_cfg_if.sv
// Interface: configuration write strobe carried from the top to each channel
interface lin_cfg_if;
    import lin_mode_pkg::*;
    logic       cfgWrite;
    lin_mode_t  cfgMode;
    chip_mode_t chipMode;
    modport top (output cfgWrite, output cfgMode, output chipMode);
    modport chan (input cfgWrite, input cfgMode, input chipMode);
endinterface

// ===== hdl/lin_transceiver_mode_control.sv
// Top: two LIN transceiver channels sharing the configuration write port
// What this block does
// - Both transceivers start off after power-up
// - Off mode selectable in every chip mode
// - Off mode ignores bus wake patterns
// - Normal mode entered by config write
// - Normal mode kept in chip normal/stop
// - Enabling delay before first frame, input high
// - Pending low at delay end not forwarded
// - Each transceiver has its own mode field
// - Driver follows transmit input in normal
// - Receive output shows bus state in normal and receive-only
// - Receive-only: driver off, receive forwarded
// - After wake, mode reads wake, rx low
// - Transmit time-out disables driver, sets flag
// - Valid wake holds receive low until mode change
module lin_transceiver_mode_control
    import lin_mode_pkg::*;
#(
    parameter int TXTO_LIMIT = TXTO_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic [2:0]  chipMode,
    input  wire logic        cfgWrite,
    input  wire logic [1:0]  cfgFirstMode,
    input  wire logic [1:0]  cfgSecondMode,
    input  wire logic [1:0]  failClear,
    input  wire logic [1:0]  linTransmitInput,
    input  wire logic [1:0]  busIn,
    output logic      [1:0]  busOut,
    output logic      [1:0]  busOe,
    output logic      [1:0]  linReceiveOutput,
    output logic      [1:0]  firstTransceiverModeField,
    output logic      [1:0]  secondTransceiverModeField,
    output logic             firstTransceiverFailureFlag,
    output logic             secondTransceiverFailureFlag,
    output logic      [1:0]  wakeEvent
);

    // ==========================================================
    // Per-channel configuration carriers
    lin_cfg_if cfgA ();
    lin_cfg_if cfgB ();
    assign cfgA.cfgWrite = cfgWrite;
    assign cfgA.cfgMode  = lin_mode_t'(cfgFirstMode);
    assign cfgA.chipMode = chip_mode_t'(chipMode);
    assign cfgB.cfgWrite = cfgWrite;
    assign cfgB.cfgMode  = lin_mode_t'(cfgSecondMode);
    assign cfgB.chipMode = chip_mode_t'(chipMode);

    lin_mode_t modeA;
    lin_mode_t modeB;
    logic [1:0] fail;

    // Open-drain: only ever pulls low
    assign busOut = 2'h0;

    lin_channel #(.TXTO_LIMIT(TXTO_LIMIT)) chanA (
        .mclk             (mclk),
        .reset            (reset),
        .cfg              (cfgA),
        .linTransmitInput (linTransmitInput[0]),
        .busIn            (busIn[0]),
        .busDriveEn       (busOe[0]),
        .linReceiveOutput (linReceiveOutput[0]),
        .modeField        (modeA),
        .failFlag         (fail[0]),
        .failClear        (failClear[0]),
        .wakeEvent        (wakeEvent[0])
    );

    lin_channel #(.TXTO_LIMIT(TXTO_LIMIT)) chanB (
        .mclk             (mclk),
        .reset            (reset),
        .cfg              (cfgB),
        .linTransmitInput (linTransmitInput[1]),
        .busIn            (busIn[1]),
        .busDriveEn       (busOe[1]),
        .linReceiveOutput (linReceiveOutput[1]),
        .modeField        (modeB),
        .failFlag         (fail[1]),
        .failClear        (failClear[1]),
        .wakeEvent        (wakeEvent[1])
    );

    assign firstTransceiverModeField    = modeA;
    assign secondTransceiverModeField   = modeB;
    assign firstTransceiverFailureFlag  = fail[0];
    assign secondTransceiverFailureFlag = fail[1];

endmodule

// ===== bench/lin_bus_model.sv
// Far-side model: the two LIN wires with pull-up and remote nodes
module lin_bus_model (
    input  wire logic [1:0] busOe,
    input  wire logic [1:0] busOut,
    input  wire logic [1:0] remoteDom,
    output logic      [1:0] busLevel
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pull-up: a released wire reads recessive, never a stale level
    assign busLevel = (busOut | ~busOe) & ~remoteDom;
endmodule

// ===== bench/tb_lin_transceiver_mode_control.sv
// Self-checking testbench for the dual LIN transceiver mode control
`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_lin_transceiver_mode_control;
    timeunit 1ns;
    timeprecision 1ns;
    import lin_mode_pkg::*;
    logic       mclk, reset, cfgWrite;
    logic [2:0] chipMode;
    logic [1:0] cfgFirst, cfgSecond, failClear, txd, remoteDom, busLevel;
    logic [1:0] busOut, busOe, rxd, mode1, mode2, wakeEvent;
    logic       fail1, fail2;
    int         miscompares, nCompared, wake0, wake1;

    lin_transceiver_mode_control #(.TXTO_LIMIT(50)) lin_transceiver_mode_control_inst (
        .mclk(mclk), .reset(reset), .chipMode(chipMode), .cfgWrite(cfgWrite),
        .cfgFirstMode(cfgFirst), .cfgSecondMode(cfgSecond), .failClear(failClear),
        .linTransmitInput(txd), .busIn(busLevel), .busOut(busOut), .busOe(busOe),
        .linReceiveOutput(rxd), .firstTransceiverModeField(mode1),
        .secondTransceiverModeField(mode2), .firstTransceiverFailureFlag(fail1),
        .secondTransceiverFailureFlag(fail2), .wakeEvent(wakeEvent));
    lin_bus_model lin_bus_model_inst (
        .busOe(busOe), .busOut(busOut), .remoteDom(remoteDom), .busLevel(busLevel));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        wake0 <= wake0 + int'(wakeEvent[0]);
        wake1 <= wake1 + int'(wakeEvent[1]);
    end

    // ==============================
    // Shared tasks
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic wr(input chip_mode_t cm, input lin_mode_t m1, input lin_mode_t m2);
        chipMode = cm;
        cfgFirst = m1;
        cfgSecond = m2;
        cfgWrite = 1'b1;
        cyc(1);
        cfgWrite = 1'b0;
        cyc(2);
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatched %0d", nCompared, miscompares);
        if (miscompares == 0 && nCompared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ==============================
    // Scenarios
    task automatic test_reset;
        `CHK("mode1", LIN_OFF, mode1)
        `CHK("mode2", 2'h0, mode2)
        `CHK("rxd", 2'b11, rxd)
        `CHK("oe", 2'b00, busOe)
        `CHK("busOut", 2'b00, busOut)
        `CHK("flags", 2'b00, {fail1, fail2})
        $display("test reset done");
    endtask
    task automatic test_off_wake;
        remoteDom = 2'b11;
        cyc(320);
        remoteDom = 2'b00;
        cyc(5);
        `CHK("wakes", 0, wake0 + wake1)
        `CHK("rxd", 2'b11, rxd)
        $display("test off wake done");
    endtask
    task automatic test_refused;
        wr(CHIP_SLEEP, LIN_NORMAL, LIN_NORMAL);
        `CHK("mode1", 2'h0, mode1)
        `CHK("mode2", 2'h0, mode2)
        wr(CHIP_SLEEP, LIN_WAKECAP, LIN_OFF);
        `CHK("mode1", 2'h1, mode1)
        wr(CHIP_SLEEP, LIN_OFF, LIN_OFF);
        `CHK("mode1", 2'h0, mode1)
        $display("test refused done");
    endtask
    task automatic test_enable;
        wr(CHIP_NORMAL, LIN_NORMAL, LIN_RXONLY);
        `CHK("mode1", 2'h3, mode1)
        `CHK("mode2", 2'h2, mode2)
        cyc(65);
        // Early dominant on purpose, kept under the time-out
        txd[0] = 1'b0;
        cyc(15);
        `CHK("oe early", 2'b00, busOe)
        cyc(30);
        `CHK("oe pending", 2'b00, busOe)
        txd[0] = 1'b1;
        cyc(2);
        txd = 2'b00;
        cyc(1);
        `CHK("oe", 2'b01, busOe)
        cyc(2);
        `CHK("rxd", 2'b10, rxd)
        txd = 2'b11;
        remoteDom = 2'b10;
        cyc(3);
        `CHK("rxd", 2'b01, rxd)
        remoteDom = 2'b00;
        chipMode = CHIP_STOP;
        cyc(3);
        `CHK("modes", 4'hE, {mode1, mode2})
        txd[0] = 1'b0;
        cyc(1);
        `CHK("oe stop", 2'b01, busOe)
        txd[0] = 1'b1;
        chipMode = CHIP_NORMAL;
        cyc(3);
        $display("test enable done");
    endtask
    task automatic test_timeout;
        txd[0] = 1'b0;
        cyc(3);
        `CHK("oe", 2'b01, busOe)
        cyc(55);
        `CHK("oe", 2'b00, busOe)
        `CHK("flags", 2'b10, {fail1, fail2})
        txd[0] = 1'b1;
        failClear = 2'b01;
        cyc(1);
        failClear = 2'b00;
        cyc(1);
        `CHK("flags", 2'b00, {fail1, fail2})
        $display("test timeout done");
    endtask
    task automatic test_wake;
        wr(CHIP_NORMAL, LIN_WAKECAP, LIN_WAKECAP);
        remoteDom = 2'b11;
        cyc(320);
        remoteDom = 2'b00;
        cyc(3);
        `CHK("wakes", 2, wake0 + wake1)
        `CHK("rxd", 2'b00, rxd)
        cyc(20);
        `CHK("rxd held", 2'b00, rxd)
        `CHK("modes", 4'h5, {mode1, mode2})
        wr(CHIP_NORMAL, LIN_OFF, LIN_WAKECAP);
        `CHK("rxd", 2'b01, rxd)
        $display("test wake done");
    endtask
    task automatic test_chip_drop;
        wr(CHIP_STOP, LIN_NORMAL, LIN_RXONLY);
        `CHK("modes", 4'h2, {mode1, mode2})
        wr(CHIP_NORMAL, LIN_NORMAL, LIN_RXONLY);
        chipMode = CHIP_FAILSAFE;
        cyc(2);
        `CHK("modes", 4'h0, {mode1, mode2})
        `CHK("oe", 2'b00, busOe)
        chipMode = CHIP_NORMAL;
        cyc(1);
        $display("test chip drop done");
    endtask

    // ==============================
    // Main sequence and watchdog
    initial begin
        reset = 1'b1;
        chipMode = CHIP_NORMAL;
        cfgWrite = 1'b0;
        cfgFirst = 2'h0;
        cfgSecond = 2'h0;
        failClear = 2'b00;
        txd = 2'b11;
        remoteDom = 2'b00;
        miscompares = 0;
        nCompared = 0;
        wake0 = 0;
        wake1 = 0;
        cyc(6);
        test_reset();
        reset = 1'b0;
        cyc(2);
        test_off_wake();
        test_refused();
        test_enable();
        test_timeout();
        test_wake();
        test_chip_drop();
        tally_and_finish();
    end
    initial begin
        // Tests need about 890 cycles
        cyc(5000);
        miscompares++;
        tally_and_finish();
    end
endmodule
